// ---- include/cpureg_pkg.sv ----
`default_nettype none
package cpureg_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ACC   = 8'h00;
   localparam logic [7:0] ADDR_X     = 8'h04;
   localparam logic [7:0] ADDR_Y     = 8'h08;
   localparam logic [7:0] ADDR_SP    = 8'h0c;
   localparam logic [7:0] ADDR_PC    = 8'h10;
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_PAIR  = 8'h18;
   localparam logic [7:0] ADDR_EA    = 8'h1c;
   // ----------------------------------------------------------------
   // flag positions, reset values, stack limits
   // ----------------------------------------------------------------
   localparam int F_C = 0;
   localparam int F_Z = 1;
   localparam int F_I = 2;
   localparam int F_H = 3;
   localparam int F_B = 4;
   localparam int F_V = 6;
   localparam int F_N = 7;
   localparam logic [7:0]  FLAGS_RST  = 8'h00;
   localparam logic [7:0]  FLAGS_MASK = 8'hdf;
   localparam logic [7:0]  PC_HI_RST  = 8'hff;
   localparam logic [7:0]  PC_LO_RST  = 8'hfe;
   localparam logic [7:0]  STACK_TOP  = 8'h7f;
   localparam logic [7:0]  CALL_DEPTH = 8'h02;
   localparam logic [7:0]  INT_DEPTH  = 8'h03;
   // ----------------------------------------------------------------
   // core operations and carriers
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP, OP_FETCH, OP_ADC, OP_SBC, OP_ASL, OP_ROR, OP_LDA,
      OP_INCX, OP_DECX, OP_INCY, OP_DECY, OP_CMPX, OP_CMPY,
      OP_TAX, OP_TAY, OP_BIT, OP_EI, OP_DI, OP_OVERFLOW_CLEAR_OP, OP_BRK,
      OP_CALL, OP_TABLE_CALL_OP, OP_IDXX, OP_IDXY
   } cpureg_op_type;
   typedef struct packed {
      cpureg_op_type op;
      logic [7:0]    operand;
      logic [15:0]   addr;
   } cpureg_req_type;
endpackage
`default_nettype wire

// ---- logic/cpureg_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpureg_core (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire cpureg_pkg::cpureg_req_type req,
   input  wire logic                      irq,
   output logic                           irq_ack,
   output logic [15:0]                    fetch_addr,
   output logic [15:0]                    eff_addr,
   output logic [15:0]                    index_accum_pair,
   output logic [7:0]                     stack_pointer,
   output logic [7:0]                     processor_flags_word
);
   import cpureg_pkg::*;

   logic [7:0]  acc_q;
   logic [7:0]  x_q;
   logic [7:0]  y_q;
   logic [7:0]  sp_q;
   logic [7:0]  pc_hi_q;
   logic [7:0]  pc_lo_q;
   logic [7:0]  fl_q;
   logic [15:0] ea_q;
   logic        ack_q;
   logic        rdy_q;
   logic        err_q;
   logic [31:0] rd_q;
   logic        wr_en;
   logic        take_irq;
   logic [8:0]  sum;
   logic [4:0]  sum_lo;
   logic [7:0]  res;
   logic [7:0]  fl_d;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   // no wait state: ready rises in the first access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         rdy_q <= 1'b0;
      end else begin
         rdy_q <= psel && !penable && !rdy_q;
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q  <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (psel && !penable) begin
         err_q <= 1'b0;
         case (paddr)
            ADDR_ACC:   rd_q <= {24'h00_0000, acc_q};
            ADDR_X:     rd_q <= {24'h00_0000, x_q};
            ADDR_Y:     rd_q <= {24'h00_0000, y_q};
            ADDR_SP:    rd_q <= {24'h00_0000, sp_q};
            ADDR_PC:    rd_q <= {16'h0000, pc_hi_q, pc_lo_q};
            ADDR_FLAGS: rd_q <= {24'h00_0000, fl_q};
            ADDR_PAIR:  rd_q <= {16'h0000, y_q, acc_q};
            ADDR_EA:    rd_q <= {16'h0000, ea_q};
            default: begin
               rd_q  <= 32'h0000_0000;
               err_q <= 1'b1;
            end
         endcase
      end
   end

   assign wr_en    = psel && penable && rdy_q && pwrite;
   assign take_irq = irq && fl_q[F_I] && req.op == OP_NOP;

   // ----------------------------------------------------------------
   // alu
   // ----------------------------------------------------------------
   // one adder serves add, subtract and compare; subtract adds the inverse
   always_comb begin
      sum    = 9'h000;
      sum_lo = 5'h00;
      res    = 8'h00;
      case (req.op)
         OP_ADC: begin
            sum    = {1'b0, acc_q} + {1'b0, req.operand} + {8'h00, fl_q[F_C]};
            sum_lo = {1'b0, acc_q[3:0]} + {1'b0, req.operand[3:0]} + {4'h0, fl_q[F_C]};
         end
         OP_SBC: begin
            sum    = {1'b0, acc_q} + {1'b0, ~req.operand} + {8'h00, fl_q[F_C]};
            sum_lo = {1'b0, acc_q[3:0]} + {1'b0, ~req.operand[3:0]} + {4'h0, fl_q[F_C]};
         end
         OP_CMPX: sum = {1'b0, x_q} + {1'b0, ~req.operand} + 9'h001;
         OP_CMPY: sum = {1'b0, y_q} + {1'b0, ~req.operand} + 9'h001;
         OP_ASL:  sum = {acc_q, 1'b0};
         OP_ROR:  sum = {acc_q[0], fl_q[F_C], acc_q[7:1]};
         OP_LDA:  sum = {1'b0, req.operand};
         OP_INCX: sum = {1'b0, x_q + 8'h01};
         OP_DECX: sum = {1'b0, x_q - 8'h01};
         OP_INCY: sum = {1'b0, y_q + 8'h01};
         OP_DECY: sum = {1'b0, y_q - 8'h01};
         OP_TAX,
         OP_TAY:  sum = {1'b0, acc_q};
         OP_BIT:  sum = {1'b0, acc_q & req.operand};
         default: sum = 9'h000;
      endcase
      res = sum[7:0];
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   always_comb begin
      fl_d = fl_q;
      case (req.op)
         OP_ADC, OP_SBC: begin
            fl_d[F_C] = sum[8];
            fl_d[F_H] = sum_lo[4];
            fl_d[F_V] = (acc_q[7] == (req.operand[7] ^ (req.op == OP_SBC)))
                        && (res[7] != acc_q[7]);
         end
         OP_ASL, OP_ROR, OP_CMPX, OP_CMPY: fl_d[F_C] = sum[8];
         OP_BIT: begin
            fl_d[F_V] = req.operand[6];
         end
         OP_EI:   fl_d[F_I] = 1'b1;
         OP_DI:   fl_d[F_I] = 1'b0;
         OP_OVERFLOW_CLEAR_OP: begin
            fl_d[F_V] = 1'b0;
            fl_d[F_H] = 1'b0;
         end
         OP_BRK:   fl_d[F_B] = 1'b1;
         OP_TABLE_CALL_OP: fl_d[F_B] = 1'b0;
         default: ;
      endcase
      case (req.op)
         OP_ADC, OP_SBC, OP_ASL, OP_ROR, OP_LDA, OP_INCX, OP_DECX,
         OP_INCY, OP_DECY, OP_CMPX, OP_CMPY, OP_TAX, OP_TAY, OP_BIT: begin
            fl_d[F_Z] = (res == 8'h00);
            fl_d[F_N] = (req.op == OP_BIT) ? req.operand[7] : res[7];
         end
         default: ;
      endcase
      if (take_irq) begin
         fl_d[F_I] = 1'b0;
      end
   end

   // servicing an interrupt beats a software write that would re-enable it
   always_ff @(posedge clk) begin
      if (rst) begin
         fl_q <= FLAGS_RST;
      end else if (wr_en && paddr == ADDR_FLAGS) begin
         fl_q      <= pwdata[7:0] & FLAGS_MASK;
         fl_q[F_I] <= pwdata[F_I] && !take_irq;
      end else begin
         fl_q <= fl_d & FLAGS_MASK;
      end
   end

   // ----------------------------------------------------------------
   // accumulator and index registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= 8'h00;
      end else if (wr_en && paddr == ADDR_ACC) begin
         acc_q <= pwdata[7:0];
      end else if (req.op inside {OP_ADC, OP_SBC, OP_ASL, OP_ROR, OP_LDA}) begin
         acc_q <= res;
      end
   end

   // index registers count, take transfers and hold data like accumulators
   always_ff @(posedge clk) begin
      if (rst) begin
         x_q <= 8'h00;
         y_q <= 8'h00;
      end else begin
         if (wr_en && paddr == ADDR_X) begin
            x_q <= pwdata[7:0];
         end else if (req.op inside {OP_INCX, OP_DECX, OP_TAX}) begin
            x_q <= res;
         end
         if (wr_en && paddr == ADDR_Y) begin
            y_q <= pwdata[7:0];
         end else if (req.op inside {OP_INCY, OP_DECY, OP_TAY}) begin
            y_q <= res;
         end
      end
   end

   // indexed address: carry out of 16 bits wraps around
   always_ff @(posedge clk) begin
      if (rst) begin
         ea_q <= 16'h0000;
      end else if (req.op == OP_IDXX) begin
         ea_q <= req.addr + {8'h00, x_q};
      end else if (req.op == OP_IDXY) begin
         ea_q <= req.addr + {8'h00, y_q};
      end
   end

   // ----------------------------------------------------------------
   // stack pointer
   // ----------------------------------------------------------------
   // no reset on purpose: software must load it, a bench sees x until then
   always_ff @(posedge clk) begin
      if (wr_en && paddr == ADDR_SP) begin
         sp_q <= pwdata[7:0];
      end else if (req.op inside {OP_CALL, OP_TABLE_CALL_OP}) begin
         sp_q <= (sp_q - CALL_DEPTH) & STACK_TOP;
      end else if (req.op == OP_BRK || take_irq) begin
         sp_q <= (sp_q - INT_DEPTH) & STACK_TOP;
      end
   end

   // ----------------------------------------------------------------
   // program counter and interrupt acknowledge
   // ----------------------------------------------------------------
   // fetch address only: no store path toward program memory exists
   always_ff @(posedge clk) begin
      if (rst) begin
         pc_hi_q <= PC_HI_RST;
         pc_lo_q <= PC_LO_RST;
      end else if (wr_en && paddr == ADDR_PC) begin
         {pc_hi_q, pc_lo_q} <= pwdata[15:0];
      end else if (req.op inside {OP_CALL, OP_TABLE_CALL_OP, OP_BRK} || take_irq) begin
         {pc_hi_q, pc_lo_q} <= req.addr;
      end else if (req.op == OP_FETCH) begin
         {pc_hi_q, pc_lo_q} <= {pc_hi_q, pc_lo_q} + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take_irq;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pready               = rdy_q;
   assign prdata               = rd_q;
   assign pslverr              = err_q;
   assign irq_ack              = ack_q;
   assign fetch_addr           = {pc_hi_q, pc_lo_q};
   assign eff_addr             = ea_q;
   assign index_accum_pair     = {y_q, acc_q};
   assign stack_pointer        = sp_q;
   assign processor_flags_word = fl_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_pc_reset;
      $past(rst) |-> fetch_addr == {PC_HI_RST, PC_LO_RST};
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("pc not at reset address");

   property p_fetch_inc;
      req.op == OP_FETCH && !wr_en |=> fetch_addr == $past(fetch_addr) + 16'h0001;
   endproperty
   a_fetch_inc: assert property (p_fetch_inc) else $error("pc did not advance");

   property p_index;
      req.op == OP_IDXX |=> eff_addr == $past(req.addr) + {8'h00, $past(x_q)};
   endproperty
   a_index: assert property (p_index) else $error("bad indexed address");

   property p_pair;
      psel && !penable && paddr == ADDR_PAIR |=> prdata == {16'h0000, $past(index_accum_pair)};
   endproperty
   a_pair: assert property (p_pair) else $error("pair mismatch");

   property p_irq_masked;
      !fl_q[F_I] |=> !irq_ack;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked irq taken");

   property p_irq_clear;
      irq_ack |-> !fl_q[F_I];
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("enable kept on service");

   property p_call_sp;
      req.op == OP_CALL && !wr_en |=> stack_pointer == (($past(sp_q) - CALL_DEPTH) & STACK_TOP);
   endproperty
   a_call_sp: assert property (p_call_sp) else $error("sp not moved by call");

   property p_overflow_clear_op;
      req.op == OP_OVERFLOW_CLEAR_OP && !wr_en |=> !fl_q[F_V] && !fl_q[F_H];
   endproperty
   a_overflow_clear_op: assert property (p_overflow_clear_op) else $error("clear overflow failed");

   property p_bit;
      req.op == OP_BIT && !wr_en |=> fl_q[F_V] == $past(req.operand[6])
                                     && fl_q[F_N] == $past(req.operand[7]);
   endproperty
   a_bit: assert property (p_bit) else $error("bit test flags wrong");

   property p_zero;
      req.op == OP_LDA && !wr_en |=> fl_q[F_Z] == (acc_q == 8'h00) && fl_q[F_N] == acc_q[7];
   endproperty
   a_zero: assert property (p_zero) else $error("zero or negative wrong");

   property p_brk;
      req.op == OP_BRK && !wr_en |=> fl_q[F_B];
   endproperty
   a_brk: assert property (p_brk) else $error("break flag not set");

   property p_apb_ready;
      psel && !penable && !pready |=> pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready late");

   property p_ei;
      req.op == OP_EI && !wr_en |=> fl_q[F_I];
   endproperty
   a_ei: assert property (p_ei) else $error("enable op did not set i");

   property p_di;
      req.op == OP_DI && !wr_en |=> !fl_q[F_I];
   endproperty
   a_di: assert property (p_di) else $error("mask op did not clear i");

   property p_brk_sp;
      req.op == OP_BRK && !wr_en |=> stack_pointer == (($past(sp_q) - INT_DEPTH) & STACK_TOP);
   endproperty
   a_brk_sp: assert property (p_brk_sp) else $error("sp not moved by break");

   property p_table_call_op;
      req.op == OP_TABLE_CALL_OP && !wr_en |=> fetch_addr == $past(req.addr) && !fl_q[F_B];
   endproperty
   a_table_call_op: assert property (p_table_call_op) else $error("table call wrong");

   property p_shift_carry;
      req.op == OP_ASL && !wr_en |=> fl_q[F_C] == $past(acc_q[7]);
   endproperty
   a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

   property p_add_ovf;
      req.op == OP_ADC && !wr_en |=> fl_q[F_V] == ($past(acc_q[7]) == $past(req.operand[7])
                                     && index_accum_pair[7] != $past(acc_q[7]));
   endproperty
   a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");

   property p_half_hold;
      !(req.op inside {OP_ADC, OP_SBC, OP_OVERFLOW_CLEAR_OP}) && !wr_en |=> fl_q[F_H] == $past(fl_q[F_H]);
   endproperty
   a_half_hold: assert property (p_half_hold) else $error("half carry changed");

   property p_no_vset;
      !(req.op inside {OP_ADC, OP_SBC, OP_BIT}) && !wr_en && !fl_q[F_V] |=> !fl_q[F_V];
   endproperty
   a_no_vset: assert property (p_no_vset) else $error("overflow set directly");

   property p_xfer_flags;
      req.op == OP_TAX && !wr_en |=> fl_q[F_N] == $past(acc_q[7])
                                     && fl_q[F_Z] == ($past(acc_q) == 8'h00);
   endproperty
   a_xfer_flags: assert property (p_xfer_flags) else $error("transfer flags wrong");

   c_irq:  cover property (irq_ack);
   c_ovf:  cover property (req.op == OP_ADC ##1 fl_q[F_V]);
   c_wrap: cover property (req.op == OP_FETCH && fetch_addr == 16'hffff);
   c_err:  cover property (pready && pslverr);
endmodule
`default_nettype wire

// ---- tb/cpu_core_registers_and_flags_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_core_registers_and_flags_bench;
   import cpureg_pkg::*;
   // ---------------------------------------------------------------
   // signals and design
   // ---------------------------------------------------------------
   logic           clk, rst, psel, penable, pwrite, pready, pslverr, irq, irq_ack, rd_err;
   logic [7:0]     paddr, stack_pointer, processor_flags_word;
   logic [31:0]    pwdata, prdata, rd_data, seed;
   logic [15:0]    fetch_addr, eff_addr, index_accum_pair;
   cpureg_req_type req;
   int             num_errors, check_count;

   cpureg_core cpureg_core_inst (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .req(req), .irq(irq), .irq_ack(irq_ack),
      .fetch_addr(fetch_addr), .eff_addr(eff_addr),
      .index_accum_pair(index_accum_pair), .stack_pointer(stack_pointer),
      .processor_flags_word(processor_flags_word));

   // free running 250 mhz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one apb transfer, entered just after an edge; the wait ends on pready, with only the watchdog as a limit
   // an idle edge follows, so a next call never re-drives psel in the same step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // one core operation, then an idle edge so results are sampled settled
   task automatic do_op(input cpureg_op_type o, input logic [7:0] v, input logic [15:0] a);
      req <= '{o, v, a};
      @(posedge clk);
      req <= '{OP_NOP, 8'h00, a};
      @(posedge clk);
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // expected {flags, result}; carry on subtract means no borrow
   function automatic logic [15:0] alu(input cpureg_op_type o, input logic [7:0] a,
                                       input logic [7:0] b, input logic c);
      logic [8:0] s;
      logic [4:0] l;
      logic [7:0] f;
      f = 8'h00;
      case (o)
         OP_ADC: begin
            s = 9'(a) + 9'(b) + 9'(c);
            l = 5'(a[3:0]) + 5'(b[3:0]) + 5'(c);
            f[3] = l[4];
            f[6] = (a[7] == b[7]) && (s[7] != a[7]);
            f[0] = s[8];
         end
         OP_SBC: begin
            s = 9'(a) - 9'(b) - 9'(!c);
            l = 5'(a[3:0]) - 5'(b[3:0]) - 5'(!c);
            f[3] = !l[4];
            f[6] = (a[7] != b[7]) && (s[7] != a[7]);
            f[0] = !s[8];
         end
         OP_ASL: begin
            s = {a, 1'b0};
            f[0] = a[7];
         end
         default: begin
            s = {1'b0, c, a[7:1]};
            f[0] = a[0];
         end
      endcase
      f[1] = (s[7:0] == 8'h00);
      f[7] = s[7];
      return {f, s[7:0]};
   endfunction

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      cpureg_op_type ops [4];
      logic [7:0]    ca [4];
      logic [7:0]    cb [4];
      logic [7:0]    a, b, m, x, y;
      logic [15:0]   e;
      int            n;
      ops = '{OP_ADC, OP_SBC, OP_ASL, OP_ROR};
      ca = '{8'h7f, 8'h80, 8'h80, 8'h01};
      cb = '{8'h01, 8'h01, 8'h00, 8'h00};
      seed = 32'h75573b0e;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq = 1'b0;
      req = '{OP_NOP, 8'h00, 16'h0000};
      num_errors = 0;
      check_count = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(fetch_addr, 16'hfffe);
      check(processor_flags_word, 8'h00);
      apb(1'b0, ADDR_PC, 32'h0);
      check(rd_data, 32'h0000fffe);
      apb(1'b1, ADDR_SP, 32'h7f);
      apb(1'b0, ADDR_SP, 32'h0);
      check(rd_data, 32'h7f);
      apb(1'b0, 8'h40, 32'h0);
      check(rd_err, 1'b1);
      check(rd_data, 32'h0);
      // alu: corner operands first, then random ones
      for (int k = 0; k < 40; k++) begin
         seed = lfsr(seed);
         a = (k < 4) ? ca[k] : seed[7:0];
         b = (k < 4) ? cb[k] : seed[15:8];
         apb(1'b1, ADDR_ACC, 32'(a));
         apb(1'b1, ADDR_FLAGS, {31'h0, seed[16]});
         do_op(ops[k % 4], b, 16'h0000);
         e = alu(ops[k % 4], a, b, seed[16]);
         m = (k % 4 < 2) ? 8'hcb : 8'h83;
         check(index_accum_pair[7:0], e[7:0]);
         check(processor_flags_word & m, e[15:8] & m);
      end
      // index registers
      seed = lfsr(seed);
      x = seed[7:0];
      y = seed[15:8];
      apb(1'b1, ADDR_X, 32'(x));
      do_op(OP_IDXX, 8'h00, 16'h1230);
      check(eff_addr, 16'h1230 + 16'(x));
      apb(1'b1, ADDR_Y, 32'(y));
      do_op(OP_INCY, 8'h00, 16'h0000);
      check(index_accum_pair[15:8], 8'(y + 8'h01));
      do_op(OP_IDXY, 8'h00, 16'hff00);
      check(eff_addr, 16'hff00 + 16'(8'(y + 8'h01)));
      do_op(OP_DECX, 8'h00, 16'h0000);
      apb(1'b0, ADDR_X, 32'h0);
      check(rd_data, 32'(8'(x - 8'h01)));
      do_op(OP_CMPX, 8'(x - 8'h01), 16'h0000);
      check(processor_flags_word & 8'h03, 8'h03);
      // bit test, overflow clear, enable and mask ops
      apb(1'b1, ADDR_ACC, 32'h0f);
      apb(1'b0, ADDR_PAIR, 32'h0);
      check(rd_data, {16'h0000, 8'(y + 8'h01), 8'h0f});
      do_op(OP_BIT, 8'hc0, 16'h0000);
      check(processor_flags_word & 8'hc2, 8'hc2);
      do_op(OP_BIT, 8'h01, 16'h0000);
      check(processor_flags_word & 8'hc2, 8'h00);
      do_op(OP_LDA, 8'h80, 16'h0000);
      do_op(OP_TAX, 8'h00, 16'h0000);
      check(processor_flags_word & 8'h82, 8'h80);
      apb(1'b0, ADDR_X, 32'h0);
      check(rd_data, 32'h80);
      apb(1'b1, ADDR_FLAGS, 32'hff);
      check(processor_flags_word, 8'hdf);
      do_op(OP_OVERFLOW_CLEAR_OP, 8'h00, 16'h0000);
      check(processor_flags_word, 8'h97);
      do_op(OP_DI, 8'h00, 16'h0000);
      check(processor_flags_word, 8'h93);
      do_op(OP_EI, 8'h00, 16'h0000);
      check(processor_flags_word, 8'h97);
      // call and break move the stack and program counter
      apb(1'b1, ADDR_PC, 32'hffff);
      do_op(OP_FETCH, 8'h00, 16'h0000);
      check(fetch_addr, 16'h0000);
      apb(1'b1, ADDR_SP, 32'h7f);
      do_op(OP_CALL, 8'h00, 16'hc123);
      check({fetch_addr, stack_pointer}, 24'hc1237d);
      do_op(OP_TABLE_CALL_OP, 8'h00, 16'hffc0);
      check({fetch_addr, stack_pointer}, 24'hffc07b);
      check(processor_flags_word[F_B], 1'b0);
      do_op(OP_BRK, 8'h00, 16'hffde);
      check({fetch_addr, stack_pointer}, 24'hffde78);
      check(processor_flags_word[F_B], 1'b1);
      // masked request waits; once enabled it is taken and masks itself
      do_op(OP_DI, 8'h00, 16'hfffa);
      irq <= 1'b1;
      repeat (4) begin
         @(posedge clk);
         check(irq_ack, 1'b0);
      end
      apb(1'b1, ADDR_FLAGS, 32'h04);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq_ack !== 1'b1 && n < 6);
      irq <= 1'b0;
      check(irq_ack, 1'b1);
      check({fetch_addr, stack_pointer}, 24'hfffa75);
      check(processor_flags_word[F_I], 1'b0);
      repeat (2) @(posedge clk);
      complete_run();
   end
endmodule
`default_nettype wire
